// [periph_reset_defs.svh]
// register offsets, field positions, masks and reset values of the peripheral reset block
`ifndef PERIPH_RESET_DEFS_SVH
`define PERIPH_RESET_DEFS_SVH

`define ADDR_W                 8
`define DATA_W                 32

`define OFS_DEBUG_PAUSE        8'h2C
`define OFS_RST_CTRL_B         8'h44
`define OFS_RST_CTRL_A         8'h48
`define OFS_RESET_CAUSE        8'h4C

`define RST_A_RESET            32'h0000_08B3
`define RST_A_MASK             32'h0000_08B2
`define RST_A_TWO_WIRE         11
`define RST_A_SERIAL_TWO       7
`define RST_A_IND_WDOG         5
`define RST_A_WIN_WDOG         4
`define RST_A_GP_TIMER         1

`define RST_B_RESET            32'h0000_339C
`define RST_B_MASK             32'h0000_3394
`define RST_B_AUTO_WAKE        13
`define RST_B_BASIC_TIMERS     12
`define RST_B_SERIAL_ONE       9
`define RST_B_SPI              8
`define RST_B_ADV_TIMER        7
`define RST_B_COMPARATOR       4
`define RST_B_ADC              2

`define DBG_RESET              32'h0000_6E3F
`define DBG_MASK               32'h0000_0663
`define DBG_WIN_WDOG           10
`define DBG_IND_WDOG           9
`define DBG_AUTO_WAKE          6
`define DBG_BASIC_TIMERS       5
`define DBG_GP_TIMER           1
`define DBG_ADV_TIMER          0

`define CAUSE_MASK             32'h0000_0379
`define CAUSE_POR_VALUE        32'h0000_0001
`define CAUSE_SOFT_RESET       9
`define CAUSE_LOCKUP           8
`define CAUSE_PIN              6
`define CAUSE_WIN_WDOG         5
`define CAUSE_IND_WDOG         4
`define CAUSE_LOW_VOLTAGE      3
`define CAUSE_POWER_ON         0
`define CAUSE_IN_W             6
`define PAUSE_N                6

`endif

// [periph_reset_pkg.sv]
// types shared by the peripheral reset block
package periph_reset_pkg;

  typedef enum logic [2:0]
  {
    SEL_NONE,
    SEL_DEBUG,
    SEL_RST_B,
    SEL_RST_A,
    SEL_CAUSE
  } reg_sel_t;

endpackage

// [periph_reset_and_reset_cause.sv]
// peripheral reset control, reset cause flags and debug pause control
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "periph_reset_defs.svh"

// What this block does
// RL1: bit 11 releases two-wire serial module
// RL2: bit 7 releases second serial port
// RL3: bits 5,4 release independent, window watchdog
// RL4: bit 1 releases general-purpose timer
// RL5: first reset register 0x48, resets 0x08B3
// RL6: second register bit 13 releases auto-wakeup timer
// RL7: bit 12 releases all basic timers
// RL8: bits 9,8 release serial port one, spi
// RL9: bit 7 releases advanced timer
// RL10: bits 4,2 release comparator and adc
// RL11: second reset register 0x44, resets 0x339C
// RL12: cause flags clear on zero write only
// RL13: cause bit 9 marks core soft reset
// RL14: cause bit 8 marks core lockup reset
// RL15: cause bit 6 marks external pin reset
// RL16: cause bit 5 marks window watchdog reset
// RL17: cause bits 4,3 mark watchdog, low voltage
// RL18: cause bit 0 marks power-on reset
// RL19: cause register 0x4C, content event dependent
// RL20: debug bits 10,9 pause both watchdogs
// RL21: debug bits 6,5 pause wakeup, basic timers
// RL22: debug bits 1,0 pause general, advanced timers
// RL23: reserved bits ignore writes, read defaults
module periph_reset_and_reset_cause
(
  input  wire logic                sys_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                por_rstn_i,
  input  wire logic [`ADDR_W-1:0]  addr_i,
  input  wire logic [`DATA_W-1:0]  wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [`DATA_W-1:0]  rdata_o,
  input  wire logic                core_halted_i,
  input  wire logic                soft_reset_cause_i,
  input  wire logic                lockup_cause_i,
  input  wire logic                pin_reset_cause_i,
  input  wire logic                window_watchdog_cause_i,
  input  wire logic                independent_watchdog_cause_i,
  input  wire logic                low_voltage_cause_i,
  output logic                     two_wire_serial_rstn_o,
  output logic                     serial_port_two_rstn_o,
  output logic                     independent_watchdog_rstn_o,
  output logic                     window_watchdog_rstn_o,
  output logic                     general_purpose_timer_rstn_o,
  output logic                     auto_wakeup_timer_rstn_o,
  output logic                     basic_timers_rstn_o,
  output logic                     serial_port_one_rstn_o,
  output logic                     spi_rstn_o,
  output logic                     advanced_timer_rstn_o,
  output logic                     voltage_comparator_rstn_o,
  output logic                     adc_rstn_o,
  output logic                     window_watchdog_pause_o,
  output logic                     independent_watchdog_pause_o,
  output logic                     auto_wakeup_timer_pause_o,
  output logic                     basic_timers_pause_o,
  output logic                     general_purpose_timer_pause_o,
  output logic                     advanced_timer_pause_o
);

  function automatic periph_reset_pkg::reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
    periph_reset_pkg::reg_sel_t sel;
    sel = periph_reset_pkg::SEL_NONE;
    unique case (addr)
      `OFS_DEBUG_PAUSE: sel = periph_reset_pkg::SEL_DEBUG;
      `OFS_RST_CTRL_B:  sel = periph_reset_pkg::SEL_RST_B;   // RL11
      `OFS_RST_CTRL_A:  sel = periph_reset_pkg::SEL_RST_A;   // RL5
      `OFS_RESET_CAUSE: sel = periph_reset_pkg::SEL_CAUSE;   // RL19
      default:          sel = periph_reset_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // masked update: writable bits come from the bus, reserved bits keep their default
  function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] data,
                                                input logic [`DATA_W-1:0] mask,
                                                input logic [`DATA_W-1:0] dflt);
    return (data & mask) | (dflt & ~mask);
  endfunction

  // flag position of the n-th reset cause input
  function automatic int cause_pos(input int n);
    int pos;
    pos = `CAUSE_LOW_VOLTAGE;
    case (n)
      5:       pos = `CAUSE_SOFT_RESET;                                                 // RL13
      4:       pos = `CAUSE_LOCKUP;                                                     // RL14
      3:       pos = `CAUSE_PIN;                                                        // RL15
      2:       pos = `CAUSE_WIN_WDOG;                                                   // RL16
      1:       pos = `CAUSE_IND_WDOG;                                                   // RL17
      0:       pos = `CAUSE_LOW_VOLTAGE;                                                // RL17
      default: pos = `CAUSE_LOW_VOLTAGE;
    endcase
    return pos;
  endfunction

  periph_reset_pkg::reg_sel_t wsel;
  periph_reset_pkg::reg_sel_t rsel;
  logic                       wr_debug;
  logic                       wr_rst_a;
  logic                       wr_rst_b;
  logic                       wr_cause;
  logic [`DATA_W-1:0]         rst_a_reg;
  logic [`DATA_W-1:0]         rst_b_reg;
  logic [`DATA_W-1:0]         debug_reg;
  logic [`DATA_W-1:0]         cause_reg;
  logic [`DATA_W-1:0]         cause_next;
  logic [`DATA_W-1:0]         cause_set;
  logic [`DATA_W-1:0]         cause_clr;
  logic [`DATA_W-1:0]         rdata_next;
  logic [`CAUSE_IN_W-1:0]     cause_raw;
  logic                       cause_meta_reg [`CAUSE_IN_W];
  logic                       cause_sync_reg [`CAUSE_IN_W];
  logic [`PAUSE_N-1:0]        pause_sel;
  logic                       pause_reg [`PAUSE_N];

  // address decode, one copy for the write path and one for the read path
  assign wsel = decode(addr_i);
  assign rsel = decode(addr_i);

  // write strobes, one for each register
  assign wr_debug = wr_i && (wsel == periph_reset_pkg::SEL_DEBUG);
  assign wr_rst_a = wr_i && (wsel == periph_reset_pkg::SEL_RST_A);                      // RL5
  assign wr_rst_b = wr_i && (wsel == periph_reset_pkg::SEL_RST_B);                      // RL11
  assign wr_cause = wr_i && (wsel == periph_reset_pkg::SEL_CAUSE);                      // RL19

  // first peripheral reset register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_a_reg <= `RST_A_RESET;                                                        // RL5
    end
    else if (wr_rst_a)
    begin
      rst_a_reg <= merge(wdata_i, `RST_A_MASK, `RST_A_RESET);                           // RL23
    end
  end

  // second peripheral reset register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_b_reg <= `RST_B_RESET;                                                        // RL11
    end
    else if (wr_rst_b)
    begin
      rst_b_reg <= merge(wdata_i, `RST_B_MASK, `RST_B_RESET);                           // RL23
    end
  end

  // debug pause configuration
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      debug_reg <= `DBG_RESET;
    end
    else if (wr_debug)
    begin
      debug_reg <= merge(wdata_i, `DBG_MASK, `DBG_RESET);                               // RL23
    end
  end

  // reset cause inputs come from the reset generator, outside this clock
  assign cause_raw = {soft_reset_cause_i, lockup_cause_i, pin_reset_cause_i,
                      window_watchdog_cause_i, independent_watchdog_cause_i, low_voltage_cause_i};

  // two-flop synchroniser for each cause input, cleared by power-on only
  generate
    for (genvar n = 0; n < `CAUSE_IN_W; n++)
    begin : g_cause_sync
      always_ff @(posedge sys_clk_i or negedge por_rstn_i)
      begin
        if (!por_rstn_i)
        begin
          cause_meta_reg[n] <= 1'h0;
          cause_sync_reg[n] <= 1'h0;
        end
        else
        begin
          cause_meta_reg[n] <= cause_raw[n];
          cause_sync_reg[n] <= cause_meta_reg[n];
        end
      end
    end
  endgenerate

  // a set in the same cycle as a clear wins
  always_comb
  begin
    cause_set = '0;
    for (int n = 0; n < `CAUSE_IN_W; n++)
    begin
      cause_set[cause_pos(n)] = cause_sync_reg[n];
    end
    cause_clr = '0;
    if (wr_cause)
    begin
      cause_clr = ~wdata_i & `CAUSE_MASK;                                               // RL12
    end
    cause_next = (cause_reg & ~cause_clr) | cause_set;
  end

  // cause flags survive system reset; of the two resets only power-on clears them and marks bit 0
  always_ff @(posedge sys_clk_i or negedge por_rstn_i)
  begin
    if (!por_rstn_i)
    begin
      cause_reg <= `CAUSE_POR_VALUE;                                                    // RL18
    end
    else
    begin
      cause_reg <= cause_next;                                                          // RL12
    end
  end

  // read data, one cycle after the read strobe
  always_comb
  begin
    rdata_next = '0;
    if (rd_i)
    begin
      unique case (rsel)
        periph_reset_pkg::SEL_DEBUG: rdata_next = debug_reg;
        periph_reset_pkg::SEL_RST_B: rdata_next = rst_b_reg;
        periph_reset_pkg::SEL_RST_A: rdata_next = rst_a_reg;
        periph_reset_pkg::SEL_CAUSE: rdata_next = cause_reg & `CAUSE_MASK;              // RL23
        periph_reset_pkg::SEL_NONE:  rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= rdata_next;
    end
  end

  // peripheral reset lines, low holds the module in reset
  assign two_wire_serial_rstn_o       = rst_a_reg[`RST_A_TWO_WIRE];                     // RL1
  assign serial_port_two_rstn_o       = rst_a_reg[`RST_A_SERIAL_TWO];                   // RL2
  assign independent_watchdog_rstn_o  = rst_a_reg[`RST_A_IND_WDOG];                     // RL3
  assign window_watchdog_rstn_o       = rst_a_reg[`RST_A_WIN_WDOG];                     // RL3
  assign general_purpose_timer_rstn_o = rst_a_reg[`RST_A_GP_TIMER];                     // RL4
  assign auto_wakeup_timer_rstn_o     = rst_b_reg[`RST_B_AUTO_WAKE];                    // RL6
  assign basic_timers_rstn_o          = rst_b_reg[`RST_B_BASIC_TIMERS];                 // RL7
  assign serial_port_one_rstn_o       = rst_b_reg[`RST_B_SERIAL_ONE];                   // RL8
  assign spi_rstn_o                   = rst_b_reg[`RST_B_SPI];                          // RL8
  assign advanced_timer_rstn_o        = rst_b_reg[`RST_B_ADV_TIMER];                    // RL9
  assign voltage_comparator_rstn_o    = rst_b_reg[`RST_B_COMPARATOR];                   // RL10
  assign adc_rstn_o                   = rst_b_reg[`RST_B_ADC];                          // RL10

  // pause choice, one debug bit for each paused counter
  assign pause_sel[5] = debug_reg[`DBG_WIN_WDOG];                                       // RL20
  assign pause_sel[4] = debug_reg[`DBG_IND_WDOG];                                       // RL20
  assign pause_sel[3] = debug_reg[`DBG_AUTO_WAKE];                                      // RL21
  assign pause_sel[2] = debug_reg[`DBG_BASIC_TIMERS];                                   // RL21
  assign pause_sel[1] = debug_reg[`DBG_GP_TIMER];                                       // RL22
  assign pause_sel[0] = debug_reg[`DBG_ADV_TIMER];                                      // RL22

  // pause flops, high one cycle after the core is halted with pausing chosen, low one cycle after either ends
  generate
    for (genvar p = 0; p < `PAUSE_N; p++)
    begin : g_pause
      always_ff @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          pause_reg[p] <= 1'h0;
        end
        else
        begin
          pause_reg[p] <= core_halted_i & pause_sel[p];
        end
      end
    end
  endgenerate

  // pause outputs straight from their flops
  assign window_watchdog_pause_o       = pause_reg[5];
  assign independent_watchdog_pause_o  = pause_reg[4];
  assign auto_wakeup_timer_pause_o     = pause_reg[3];
  assign basic_timers_pause_o          = pause_reg[2];
  assign general_purpose_timer_pause_o = pause_reg[1];
  assign advanced_timer_pause_o        = pause_reg[0];

endmodule

// [periph_reset_checker_asserts.sv]
// concurrent checks on the ports of the peripheral reset block
`timescale 1ns/10ps
`include "periph_reset_defs.svh"
module periph_reset_checker
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [31:0] rdata_o,
  input  wire logic        core_halted_i,
  input  wire logic        two_wire_serial_rstn_o, serial_port_two_rstn_o, independent_watchdog_rstn_o,
  input  wire logic        window_watchdog_rstn_o, general_purpose_timer_rstn_o, auto_wakeup_timer_rstn_o,
  input  wire logic        basic_timers_rstn_o, serial_port_one_rstn_o, spi_rstn_o, advanced_timer_rstn_o,
  input  wire logic        voltage_comparator_rstn_o, adc_rstn_o, window_watchdog_pause_o,
  input  wire logic        independent_watchdog_pause_o, auto_wakeup_timer_pause_o, basic_timers_pause_o,
  input  wire logic        general_purpose_timer_pause_o, advanced_timer_pause_o
);
  wire logic [4:0]  ra = {two_wire_serial_rstn_o, serial_port_two_rstn_o, independent_watchdog_rstn_o,
                          window_watchdog_rstn_o, general_purpose_timer_rstn_o};
  wire logic [6:0]  rb = {auto_wakeup_timer_rstn_o, basic_timers_rstn_o, serial_port_one_rstn_o, spi_rstn_o,
                          advanced_timer_rstn_o, voltage_comparator_rstn_o, adc_rstn_o};
  wire logic [5:0]  pz = {window_watchdog_pause_o, independent_watchdog_pause_o, auto_wakeup_timer_pause_o,
                          basic_timers_pause_o, general_purpose_timer_pause_o, advanced_timer_pause_o};
  logic      [31:0] wq;
  logic      [31:0] wq2;
  // write data of one and two cycles back
  always_ff @(posedge sys_clk_i) wq <= wdata_i;
  always_ff @(posedge sys_clk_i) wq2 <= wq;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_A_WRITE: assert property (wr_i && addr_i == `OFS_RST_CTRL_A |=> ra == {wq[11], wq[7], wq[5:4], wq[1]})
    else $error("reset lines a differ from write");
  AST_B_WRITE: assert property (wr_i && addr_i == `OFS_RST_CTRL_B |=> rb == {wq[13:12], wq[9:7], wq[4], wq[2]})
    else $error("reset lines b differ from write");
  AST_A_READ: assert property (rd_i && addr_i == `OFS_RST_CTRL_A |=>
    rdata_o == {20'h0, ra[4], 3'h0, ra[3], 1'h0, ra[2:1], 2'h0, ra[0], 1'h1}) else $error("read a wrong");
  AST_B_READ: assert property (rd_i && addr_i == `OFS_RST_CTRL_B |=>
    rdata_o == {18'h0, rb[6:5], 2'h0, rb[4:2], 2'h0, rb[1], 1'h1, rb[0], 2'h0}) else $error("read b wrong");
  AST_CAUSE_RSVD: assert property (rd_i && addr_i == `OFS_RESET_CAUSE |=> (rdata_o & ~`CAUSE_MASK) == 32'h0)
    else $error("cause reserved bits set");
  AST_DBG_RSVD: assert property (rd_i && addr_i == `OFS_DEBUG_PAUSE |=> (rdata_o & ~`DBG_MASK) == 32'h681C)
    else $error("debug reserved bits wrong");
  AST_UNMAPPED: assert property (rd_i && !(addr_i inside {8'h2C, 8'h44, 8'h48, 8'h4C}) |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  AST_PAUSE: assert property (wr_i && addr_i == `OFS_DEBUG_PAUSE ##1 core_halted_i && !wr_i |=>
    pz == {wq2[10:9], wq2[6:5], wq2[1:0]}) else $error("pause lines differ from debug write");
  AST_PAUSE_IDLE: assert property (!core_halted_i |=> pz == 6'h00)
    else $error("pause while running");
  cover property (rd_i && addr_i == `OFS_RESET_CAUSE ##1 rdata_o != 32'h0);
  cover property (core_halted_i ##1 pz != 6'h00);
  cover property (wr_i && addr_i == `OFS_RESET_CAUSE);
endmodule

bind periph_reset_and_reset_cause periph_reset_checker i_chk (.*);

// [periph_far_model.sv]
// model of the peripherals and core that face the block
`timescale 1ns/10ps
module periph_far_model
(
  input  wire logic       sys_clk_i,
  input  wire logic       fire_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       halt_i,
  output logic      [5:0] cause_o = 6'h00,
  output logic            halted_o = 1'h0
);
  // one-cycle reset event from the chosen source
  always @(posedge sys_clk_i) cause_o <= fire_i ? 6'h01 << sel_i : 6'h00;
  always @(posedge sys_clk_i) halted_o <= halt_i;
endmodule

// [tb_periph_reset_and_reset_cause.sv]
// self-checking bench of the peripheral reset block
`timescale 1ns/10ps
`include "periph_reset_defs.svh"
`define CMP(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_periph_reset_and_reset_cause;
  logic        sys_clk_i = 1'h0, rstn_i = 1'h0, por_rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, fire = 1'h0, halt = 1'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [2:0]  sel = 3'h0;
  logic [31:0] wdata_i = 32'h0, seed = 32'h4AD9, w, r, e = 32'h0;
  wire         core_halted_i, soft_reset_cause_i, lockup_cause_i, pin_reset_cause_i, window_watchdog_cause_i;
  wire         independent_watchdog_cause_i, low_voltage_cause_i, two_wire_serial_rstn_o, serial_port_two_rstn_o;
  wire         independent_watchdog_rstn_o, window_watchdog_rstn_o, general_purpose_timer_rstn_o, spi_rstn_o;
  wire         auto_wakeup_timer_rstn_o, basic_timers_rstn_o, serial_port_one_rstn_o, advanced_timer_rstn_o;
  wire         voltage_comparator_rstn_o, adc_rstn_o, window_watchdog_pause_o, independent_watchdog_pause_o;
  wire         auto_wakeup_timer_pause_o, basic_timers_pause_o, general_purpose_timer_pause_o, advanced_timer_pause_o;
  wire [31:0]  rdata_o;
  wire [17:0]  lines = {two_wire_serial_rstn_o, serial_port_two_rstn_o, independent_watchdog_rstn_o,
                 window_watchdog_rstn_o, general_purpose_timer_rstn_o, auto_wakeup_timer_rstn_o, basic_timers_rstn_o,
                 serial_port_one_rstn_o, spi_rstn_o, advanced_timer_rstn_o, voltage_comparator_rstn_o, adc_rstn_o,
                 window_watchdog_pause_o, independent_watchdog_pause_o, auto_wakeup_timer_pause_o,
                 basic_timers_pause_o, general_purpose_timer_pause_o, advanced_timer_pause_o};
  int          fails = 0, checked = 0, cyc = 0, k;
  localparam int          CB [6]  = '{3, 4, 5, 6, 8, 9};
  localparam logic [7:0]  OFS [3] = '{`OFS_RST_CTRL_A, `OFS_RST_CTRL_B, `OFS_DEBUG_PAUSE};
  localparam logic [31:0] MSK [3] = '{`RST_A_MASK, `RST_B_MASK, `DBG_MASK};
  localparam logic [31:0] DFT [3] = '{`RST_A_RESET, `RST_B_RESET, `DBG_RESET};
  logic [31:0] m [3] = DFT;

  periph_reset_and_reset_cause i_dut (.*);
  periph_far_model i_far (.sys_clk_i(sys_clk_i), .fire_i(fire), .sel_i(sel), .halt_i(halt), .halted_o(core_halted_i),
    .cause_o({soft_reset_cause_i, lockup_cause_i, pin_reset_cause_i, window_watchdog_cause_i,
              independent_watchdog_cause_i, low_voltage_cause_i}));

  initial forever #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (++cyc == 20000) summarize(1);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [17:0] exp_lines();
    return {m[0][11], m[0][7], m[0][5:4], m[0][1], m[1][13:12], m[1][9:7], m[1][4], m[1][2],
            m[2][10:9], m[2][6:5], m[2][1:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge sys_clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge sys_clk_i);
    rd_i <= 1'h0;
    #1 r = rdata_o;
  endtask
  task automatic summarize(input int late);
    fails += late;
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    por_rstn_i <= 1'h1;
    halt <= 1'h1;
    `CMP("reset lines", 12'hFFF, lines[17:6])
    rd(`OFS_RESET_CAUSE); `CMP("cause at power-on", `CAUSE_POR_VALUE, r)
    for (int i = 0; i < 33; i++)
    begin
      k = i % 3;
      w = (i < 3) ? 32'h0 : (i < 6) ? 32'hFFFF_FFFF : xs();
      if (i >= 3) wr(OFS[k], w);
      if (i >= 3) m[k] = (w & MSK[k]) | (DFT[k] & ~MSK[k]);
      @(posedge sys_clk_i);
      #1 `CMP("lines", exp_lines(), lines)
      rd(OFS[k]); `CMP("readback", m[k], r)
    end
    @(posedge sys_clk_i) halt <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    #1 `CMP("pause idle", 6'h00, lines[5:0])
    wr(8'h4D, 32'h0); rd(8'h4D); `CMP("unmapped", 32'h0, r)
    rd(`OFS_RESET_CAUSE); `CMP("cause kept", `CAUSE_POR_VALUE, r)
    wr(`OFS_RESET_CAUSE, 32'h0); rd(`OFS_RESET_CAUSE); `CMP("cause clear", 32'h0, r)
    for (int j = 0; j < 6; j++)
    begin
      @(posedge sys_clk_i) fire <= 1'h1;
      sel <= j[2:0];
      @(posedge sys_clk_i) fire <= 1'h0;
      repeat (6) @(posedge sys_clk_i);
      e |= 32'h1 << CB[j];
      rd(`OFS_RESET_CAUSE); `CMP("cause set", e, r)
    end
    wr(`OFS_RESET_CAUSE, 32'hFFFF_FFFF); rd(`OFS_RESET_CAUSE); `CMP("write one", e, r)
    @(posedge sys_clk_i) rstn_i <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    `CMP("lines after reset", 12'hFFF, lines[17:6])
    rd(OFS[0]); `CMP("reg a after reset", DFT[0], r)
    rd(`OFS_RESET_CAUSE); `CMP("cause survives", e, r)
    wr(`OFS_RESET_CAUSE, 32'h0); rd(`OFS_RESET_CAUSE); `CMP("cause cleared", 32'h0, r)
    @(posedge sys_clk_i) fire <= 1'h1;
    sel <= 3'h5;
    @(posedge sys_clk_i) fire <= 1'h0;
    @(posedge sys_clk_i);
    wr(`OFS_RESET_CAUSE, 32'h0); rd(`OFS_RESET_CAUSE); `CMP("set beats clear", 32'h1 << CB[5], r)
    summarize(0);
  end
endmodule
